// >>> rtl/csp_config_status.sv
`timescale 1ns/1ps
`default_nettype none
module csp_config_status (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               clear_req_b_i,      // Clear-request pin, active low
  input  wire logic               init_b_i,           // Init line level from pad
  input  wire logic [2:0]         config_mode_select_i,
  input  wire csp_pkg::csp_tpin_s tpin_i,             // Test pins from pads
  input  wire logic               cfg_error_i,        // Loader saw bad data
  input  wire logic               cfg_load_done_i,    // Loader finished
  input  wire logic               scan_enable_primitive_i,
  input  wire csp_pkg::csp_pad_s  user_init_i,        // User drive after config
  input  wire csp_pkg::csp_pad_s  user_hi_i,
  input  wire csp_pkg::csp_pad_s  user_lo_i,
  output var  logic               init_b_o,
  output var  logic               init_b_oe_o,
  output var  csp_pkg::csp_pad_s  config_active_high_flag_o,
  output var  csp_pkg::csp_pad_s  config_active_low_flag_o,
  output var  logic               done_o,
  output var  logic               loading_o,          // Loader may run
  output var  logic [2:0]         mode_o,             // Latched mode
  output var  logic               master_o,
  output var  logic               scan_en_o,
  output logic                    scan_tpin_valid_o,
  output csp_pkg::csp_tpin_s      scan_tpin_o,        // Unregistered scan path
  output var  csp_pkg::csp_tpin_s user_tpin_o
);
  import csp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYN_W-1:0] syn_raw;     // Pad levels
  logic [SYN_W-1:0] syn_q1;      // First stage, read only by second stage
  logic [SYN_W-1:0] syn;         // Safe levels

  assign syn_raw = {tpin_i, config_mode_select_i, init_b_i, clear_req_b_i};

  // One two-stage synchroniser per pad input
  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          syn_q1[gi] <= 1'b1;
          syn[gi]    <= 1'b1;
        end else begin
          syn_q1[gi] <= syn_raw[gi];
          syn[gi]    <= syn_q1[gi];
        end
      end
    end
  endgenerate

  logic clr_req;   // Clear requested
  logic init_hi;   // Init line high at pad
  assign clr_req = !syn[SYN_CLR];
  assign init_hi = syn[SYN_INIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  csp_state_e       state;
  logic [CNT_W-1:0] cnt;        // Cycle counter per state
  logic             extra_done; // Final full clear pass started
  logic             err;        // Sticky data error
  logic [2:0]       mode;

  // Clear runs whole cycles; a request extends them without resetting the count, release adds one pass
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state      <= CSP_POR;
      cnt        <= '0;
      extra_done <= 1'b0;
    end else begin
      unique case (state)
        CSP_POR: begin
          // Power stabilisation before the first clear
          if (cnt == POR_CYCLES - 14'h0001) begin
            state <= CSP_CLEAR;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 14'h0001;
          end
        end
        CSP_CLEAR: begin
          if (cnt == CLEAR_CYCLES - 14'h0001) begin
            cnt <= '0;
            if (clr_req) begin
              extra_done <= 1'b0;
            end else if (!extra_done) begin
              extra_done <= 1'b1;
            end else begin
              state <= CSP_WAIT;
            end
          end else begin
            cnt <= cnt + 14'h0001;
            if (clr_req) begin
              extra_done <= 1'b0;
            end
          end
        end
        CSP_WAIT: begin
          // Outside party holds init low to keep us here
          cnt <= '0;
          if (clr_req) begin
            state <= CSP_CLEAR;
            extra_done <= 1'b0;
          end else if (init_hi) begin
            state <= MASTER_MAP[syn[SYN_MODE +: 3]] ? CSP_DELAY : CSP_CONFIG;
          end
        end
        CSP_DELAY: begin
          // Master wait; a new low on init restarts it
          if (clr_req) begin
            state <= CSP_CLEAR;
            cnt   <= '0;
            extra_done <= 1'b0;
          end else if (!init_hi) begin
            state <= CSP_WAIT;
            cnt   <= '0;
          end else if (cnt == MASTER_WAIT - 14'h0001) begin
            state <= CSP_CONFIG;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 14'h0001;
          end
        end
        CSP_CONFIG: begin
          cnt <= '0;
          if (clr_req) begin
            state <= CSP_CLEAR;
            extra_done <= 1'b0;
          end else if (cfg_load_done_i && !err && !cfg_error_i) begin
            state <= CSP_USER;
          end
        end
        CSP_USER: begin
          cnt <= '0;
          if (clr_req) begin
            state <= CSP_CLEAR;
            extra_done <= 1'b0;
          end
        end
        default: begin
          state <= CSP_POR;
          cnt   <= '0;
        end
      endcase
    end
  end

  // Data error stays pending until memory is cleared again
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err <= 1'b0;
    end else if (state == CSP_CONFIG && cfg_error_i) begin
      err <= 1'b1;
    end else if (state == CSP_CLEAR) begin
      err <= 1'b0;
    end
  end

  // Mode captured on the rising init edge out of the wait state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode <= 3'h0;
    end else if (state == CSP_WAIT && init_hi) begin
      mode <= syn[SYN_MODE +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin outputs
  logic init_low;   // Device pulls init low
  assign init_low = (state == CSP_POR) || (state == CSP_CLEAR) || err;

  // Init: open drain during config, user pin after
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_b_o    <= 1'b0;
      init_b_oe_o <= 1'b1;
    end else if (state == CSP_USER) begin
      init_b_o    <= user_init_i.out;
      init_b_oe_o <= user_init_i.oe;
    end else begin
      init_b_o    <= 1'b0;
      init_b_oe_o <= init_low;
    end
  end

  // Busy flags drive hard until user I/O become active
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      config_active_high_flag_o <= '{out: 1'b1, oe: 1'b1};
      config_active_low_flag_o  <= '{out: 1'b0, oe: 1'b1};
    end else if (state == CSP_USER) begin
      config_active_high_flag_o <= user_hi_i;
      config_active_low_flag_o  <= user_lo_i;
    end else begin
      config_active_high_flag_o <= '{out: 1'b1, oe: 1'b1};
      config_active_low_flag_o  <= '{out: 1'b0, oe: 1'b1};
    end
  end

  // Status outputs toward the loader
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o    <= 1'b0;
      loading_o <= 1'b0;
      mode_o    <= 3'h0;
      master_o  <= 1'b0;
    end else begin
      done_o    <= (state == CSP_USER);
      loading_o <= (state == CSP_CONFIG) && !err;
      mode_o    <= mode;
      master_o  <= MASTER_MAP[mode];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary scan
  // Scan path bypasses all flops so test timing is pad-to-logic
  assign scan_tpin_o       = tpin_i;
  assign scan_tpin_valid_o = scan_en_o;

  // Scan lives through config; after it only with the primitive present
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_en_o   <= 1'b1;
      user_tpin_o <= '0;
    end else begin
      scan_en_o   <= (state != CSP_USER) || scan_enable_primitive_i;
      user_tpin_o <= (state == CSP_USER && !scan_enable_primitive_i) ? syn[SYN_TP +: 3] : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Own count of cycles in the master wait, kept apart from the sequencer counter
  // so that a wrong compare in the sequencer cannot hide itself from the check
  logic [CNT_W-1:0] dly_seen;   // Cycles spent in DELAY so far

  // Restarts whenever the wait is left, as the sequencer's wait does
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dly_seen <= '0;
    end else if (state == CSP_DELAY) begin
      dly_seen <= dly_seen + 14'h0001;
    end else begin
      dly_seen <= '0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_HI_FLAG: assert property ($past(state) != CSP_USER |-> config_active_high_flag_o == 2'b11)
    else $error("high busy flag not driven high");
  AST_LO_FLAG: assert property ($past(state) != CSP_USER |-> config_active_low_flag_o == 2'b01)
    else $error("low busy flag not driven low");
  AST_INIT_CLR: assert property (state == CSP_CLEAR |=> init_b_oe_o && !init_b_o)
    else $error("init not pulled low during clear");
  AST_HOLD: assert property (state == CSP_WAIT && !init_hi && !clr_req |=> state == CSP_WAIT)
    else $error("left wait while init held low");
  AST_MWAIT: assert property (state == CSP_DELAY && dly_seen < MASTER_WAIT - 14'h0001 |=> state != CSP_CONFIG)
    else $error("master wait ended early");
  AST_ERR: assert property (state == CSP_CONFIG && cfg_error_i |=> ##1 init_b_oe_o)
    else $error("error not flagged on init");
  AST_SCAN: assert property (state == CSP_USER && !scan_enable_primitive_i |=> !scan_en_o)
    else $error("scan still enabled");
  AST_CLRX: assert property ($fell(state == CSP_CLEAR) |-> $past(extra_done) && !$past(clr_req))
    else $error("clear left without extra pass");
  AST_DONE: assert property ($rose(state == CSP_USER) |=> done_o && $past(cfg_load_done_i, 2))
    else $error("done not raised after load");
  AST_REL: assert property (init_b_oe_o && $past(state) == CSP_CONFIG |-> $past(err))
    else $error("init held without error");

endmodule
`default_nettype wire

// >>> rtl/csp_pkg.sv
// Overview of operation
// - High-active busy flag high until user I/O
// - Low-active busy flag low until user I/O
// - Init line low during power-up and clearing
// - External low on init holds wait state
// - Master modes wait 30-300 us after init
// - Init driven low on configuration data error
// - Pins become user pins once I/O active
// - Scan disabled after config without scan primitive
// - Test pins reach scan logic unregistered
// - Clear request restarts clearing, one extra cycle
// - Mode pins sampled once init goes high
// - Done output signals configuration complete
package csp_pkg;

  // Clock rate and documented master wait window
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned WAIT_MIN_US    = 30;
  localparam int unsigned WAIT_MAX_US    = 300;
  // Least time rounds up; 30 us is an exact multiple at 40 MHz
  localparam int unsigned WAIT_MIN_CYC   = (WAIT_MIN_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned WAIT_MAX_CYC   = (WAIT_MAX_US * CLK_MHZ * 1000) / 1000;

  // Counter widths and counts chosen for this block
  localparam int unsigned CNT_W          = 14;
  localparam logic [13:0] MASTER_WAIT    = 14'(WAIT_MIN_CYC);
  localparam logic [13:0] POR_CYCLES     = 14'h0040;
  localparam logic [13:0] CLEAR_CYCLES   = 14'h0100;

  // Mode codes treated as master modes, one bit per mode code
  localparam logic [7:0]  MASTER_MAP     = 8'h0F;

  // Synchroniser lane positions
  localparam int unsigned SYN_W          = 8;
  localparam int unsigned SYN_CLR        = 0;
  localparam int unsigned SYN_INIT       = 1;
  localparam int unsigned SYN_MODE       = 2;
  localparam int unsigned SYN_TP         = 5;

  // Configuration sequence states
  typedef enum logic [2:0] {
    CSP_POR    = 3'b000,
    CSP_CLEAR  = 3'b001,
    CSP_WAIT   = 3'b010,
    CSP_DELAY  = 3'b011,
    CSP_CONFIG = 3'b100,
    CSP_USER   = 3'b101
  } csp_state_e;

  // Open-drain or user pin drive pair
  typedef struct packed {
    logic out;
    logic oe;
  } csp_pad_s;

  // Boundary-scan test inputs
  typedef struct packed {
    logic tdi;
    logic tck;
    logic tms;
  } csp_tpin_s;

endpackage

// >>> bench/csp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Configuration host: pull-up on init, clear pin, loader
module csp_host_model (
  input  wire logic       clk_i,
  input  wire logic       init_b_i,       // Device pad value
  input  wire logic       init_b_oe_i,    // Device pad enable
  input  wire logic       loading_i,      // Device accepts data
  input  wire logic       hold_init_i,    // Host keeps device waiting
  input  wire logic       clear_i,        // Host asks for a clear
  input  wire logic       inject_error_i, // Host sends bad data
  input  wire logic [7:0] load_delay_i,   // Cycles of data to send
  output logic            init_wire_o,
  output logic            clear_req_b_o,
  output logic            cfg_error_o,
  output logic            cfg_load_done_o
);
  logic [7:0] cnt; // Data cycles sent so far
  // Wire is pulled up; either party may sink it
  assign init_wire_o   = !((init_b_oe_i && !init_b_i) || hold_init_i);
  assign clear_req_b_o = !clear_i;
  assign cfg_error_o   = inject_error_i && loading_i;
  // Restart the load whenever init is low, so slow hosts stay in step
  always_ff @(posedge clk_i) begin
    if (!init_wire_o) begin
      cnt <= 8'h00;
    end else if (loading_i && cnt != load_delay_i) begin
      cnt <= cnt + 8'h01;
    end
  end
  assign cfg_load_done_o = loading_i && (cnt == load_delay_i);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csp_pkg::*;
  logic       clk = 1'b0, rst_b = 1'b0, hold_init = 1'b1, clear_req = 1'b0;
  logic       inject_err = 1'b0, scan_prim = 1'b0;
  csp_pad_s   user_init = 2'h3; // User drive on init after config: out high, oe high
  logic [7:0] load_delay = 8'hFF;
  logic [2:0] mode_sel = 3'h6; // Slave code until just before release
  csp_tpin_s  tpin = 3'h5;
  logic       init_wire, clear_b, cfg_err, load_done, init_b, init_oe, done, loading, master, scan_en, scan_vld;
  csp_pad_s   hi_flag, lo_flag;
  logic [2:0] mode;
  csp_tpin_s  scan_tp, user_tp;
  int         mismatches = 0, compares = 0, n;
  always #12.5 clk = ~clk;
  csp_config_status u_dut (.clk_i(clk), .rst_b_i(rst_b), .clear_req_b_i(clear_b), .init_b_i(init_wire),
    .config_mode_select_i(mode_sel), .tpin_i(tpin), .cfg_error_i(cfg_err), .cfg_load_done_i(load_done),
    .scan_enable_primitive_i(scan_prim), .user_init_i(user_init), .user_hi_i(2'h1), .user_lo_i(2'h2),
    .init_b_o(init_b), .init_b_oe_o(init_oe), .config_active_high_flag_o(hi_flag),
    .config_active_low_flag_o(lo_flag), .done_o(done), .loading_o(loading), .mode_o(mode), .master_o(master),
    .scan_en_o(scan_en), .scan_tpin_valid_o(scan_vld), .scan_tpin_o(scan_tp), .user_tpin_o(user_tp));
  csp_host_model u_host (.clk_i(clk), .init_b_i(init_b), .init_b_oe_i(init_oe), .loading_i(loading),
    .hold_init_i(hold_init), .clear_i(clear_req), .inject_error_i(inject_err), .load_delay_i(load_delay),
    .init_wire_o(init_wire), .clear_req_b_o(clear_b), .cfg_error_o(cfg_err), .cfg_load_done_o(load_done));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_range(input string what, input int cnt, input int lo, input int hi);
    compares++;
    if (cnt < lo || cnt > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, cnt);
    end
  endtask
  // Bounded wait: 0 init released, 1 loading, 2 done
  task automatic wait_for(input int sel, input int limit, output int cnt);
    cnt = 0;
    while (!(sel == 0 ? init_oe === 1'b0 : sel == 1 ? loading === 1'b1 : done === 1'b1)) begin
      @(negedge clk);
      cnt++;
      if (cnt > limit) begin
        chk_range("wait bound", cnt, 0, limit);
        tally_and_finish();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Pins hold their configuration values through power-up and clearing
  task automatic t_power_up();
    n = 0;
    while (init_oe !== 1'b0 && n < 700) begin
      chk("pins in clear", 16'h0034, {10'h0, hi_flag, lo_flag, init_b, done});
      @(negedge clk);
      n++;
    end
    chk_range("power up cycles", n, 570, 600);
    $display("test power_up done");
  endtask
  // Held init blocks start; master waits at least 30 us
  task automatic t_master_wait();
    repeat (50) @(negedge clk);
    chk("loading while held", 16'h0, {15'h0, loading});
    mode_sel = 3'h2;
    hold_init = 1'b0;
    wait_for(1, 13000, n);
    chk_range("master wait cycles", n, 1200, 12000);
    chk("mode and master", 16'h5, {12'h0, mode, master});
    chk("scan path", 16'h5, {13'h0, scan_tp});
    $display("test master_wait done");
  endtask
  // Data error sinks init and blocks done
  task automatic t_error();
    inject_err = 1'b1;
    @(negedge clk);
    inject_err = 1'b0;
    repeat (3) @(negedge clk);
    chk("pad on error", 16'h2, {14'h0, init_oe, init_b});
    repeat (400) @(negedge clk);
    chk("pad and done later", 16'h2, {13'h0, done, init_oe, init_b});
    $display("test error done");
  endtask
  // Clear request runs one more full pass, then slave starts at once
  task automatic t_clear_slave();
    clear_req = 1'b1;
    mode_sel = 3'h5;
    load_delay = 8'h04;
    repeat (10) @(negedge clk);
    clear_req = 1'b0;
    wait_for(0, 1000, n);
    chk_range("clear finish cycles", n, 256, 520);
    wait_for(1, 8, n);
    chk_range("slave start cycles", n, 1, 8);
    chk("mode and master", 16'hA, {12'h0, mode, master});
    wait_for(2, 20, n);
    chk_range("done cycles", n, 4, 20);
    $display("test clear_slave done");
  endtask
  // Pins become user pins; scan shut without primitive
  task automatic t_user();
    repeat (4) @(negedge clk);
    chk("flags in user", 16'h6, {12'h0, hi_flag, lo_flag});
    chk("init in user", 16'h3, {14'h0, init_b, init_oe});
    chk("scan enable", 16'h0, {14'h0, scan_en, scan_vld});
    chk("user test pins", 16'h5, {13'h0, user_tp});
    tpin = 3'h2;
    #1;
    chk("scan path live", 16'h2, {13'h0, scan_tp});
    scan_prim = 1'b1;
    @(negedge clk);
    chk("scan kept", 16'h18, {11'h0, scan_en, scan_vld, user_tp});
    $display("test user done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_power_up();
    t_master_wait();
    t_error();
    t_clear_slave();
    t_user();
    tally_and_finish();
  end
endmodule
`default_nettype wire
